/* hw/otfc_ctrl.sv */
`timescale 1ns/1ps
`include "otfc_consts.svh"
// Functional notes
// - Fault threshold exceeded sets status, raises alert
// - Fault flag holds until 20 degrees below
// - Bandgap faults always shut down, then restart
// - Bandgap faults restart at once on retry 000, after the delay on 111
// - Ignore select keeps output running, flags set
// - Shutdown select stops output, then retry setting
// - Retry 000 holds output off after a threshold fault until cleared
// - Retry 111 restarts soft start without limit
// - Mixed retry values rejected with CML alert
// - Only bits 7 and 5 stored; retry fields mirror bit 5
// - Delay 111 waits seven rise times first
// - Delay 000 means no delay, output held
// - Warning threshold exceeded sets status, raises alert
// - Warning flag holds until 20 degrees below
// - Warning at or above fault limit rejected
// - Bypass bit skips the limit ordering check
// - Restore warning as fault minus 25, floor 100
// - Warning exponent fixed at zero, read only
// - Warning mantissa bounded 100 to 140 degrees
// - Store command saves fault action to memory
// - Fault threshold default 145 gives warning 120
module otfc_ctrl #(
   parameter int MS_CYCLES = `OTFC_MS_NS / `OTFC_CLK_NS
) (
   // Clock and reset.
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Host command port and read answer.
   input  wire otfc_pkg::otfc_cmd_s  cmd,
   output logic [15:0]               rdData,
   output logic                      rdValid,
   input  wire logic                 clearFaults,
   // Temperature sensor pins, sampled from its own clock.
   input  wire logic                 tempClk,
   input  wire logic [7:0]           tempValue,
   input  wire logic                 bandgapOt,
   // Neighbouring blocks on the same clock.
   input  wire logic [7:0]           faultLimit,
   input  wire logic [6:0]           riseTimeMs,
   input  wire logic                 limit_check_bypass,
   input  wire logic                 outputCommandOn,
   // Nonvolatile memory restore and store.
   input  wire logic                 restoreDefaults,
   input  wire logic                 nvmShutdownBit,
   input  wire logic                 nvmRetryBit,
   input  wire logic                 storeDefaultAll,
   output logic                      nvmSave,
   output logic [1:0]                nvmSaveData,
   // Status, alert and output control.
   output otfc_pkg::otfc_status_s    status,
   output logic                      smbAlert,
   output logic                      outputEnable,
   output logic                      softStartReq
);

   logic [2:0]             tempClkSync;
   logic [7:0]             tempMeta;
   logic [7:0]             temp;
   logic [1:0]             bandgapSync;
   logic                   sample;
   logic [7:0]             actionReg;
   logic [7:0]             warnReg;
   logic                   faultSet;
   logic                   faultRelease;
   logic                   warnSet;
   logic                   warnRelease;
   logic                   actionWrite;
   logic                   actionBad;
   logic                   warnWrite;
   logic                   warnBad;
   logic [7:0]             next_warnDefault;
   logic                   bandgapCause;
   logic [9:0]             riseLeft;
   logic [31:0]            msCount;
   otfc_pkg::otfc_state_e  state;
   otfc_pkg::otfc_state_e  next_state;
   logic                   faultFlag;
   logic                   warnFlag;
   logic                   cmlFlag;
   logic                   invalidFlag;

   // Assertions below share the system clock and are off during reset.
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Two-flop synchronisers for the sensor clock, data and bandgap pin.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tempClkSync <= 3'h0;
         tempMeta    <= 8'h00;
         temp        <= 8'h00;
         bandgapSync <= 2'h0;
      end else begin
         tempClkSync <= {tempClkSync[1:0], tempClk};
         tempMeta    <= tempValue;
         temp        <= tempMeta;
         bandgapSync <= {bandgapSync[0], bandgapOt};
      end
   end

   // A rising sensor clock edge marks a fresh temperature sample.
   assign sample = tempClkSync[1] & ~tempClkSync[2];

   // Threshold tests with 20 degree hysteresis on release.
   assign faultSet     = sample && (temp > faultLimit);
   assign faultRelease = sample && ({1'b0, temp} + {1'b0, `OTFC_HYST_DEG} <= {1'b0, faultLimit});
   assign warnSet      = sample && (temp > warnReg);
   assign warnRelease  = sample && ({1'b0, temp} + {1'b0, `OTFC_HYST_DEG} <= {1'b0, warnReg});

   // Latched fault and warning flags.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         faultFlag <= 1'b0;
         warnFlag  <= 1'b0;
      end else begin
         if (faultSet) begin
            faultFlag <= 1'b1;
         end else if (faultRelease) begin
            faultFlag <= 1'b0;
         end
         if (warnSet) begin
            warnFlag <= 1'b1;
         end else if (warnRelease) begin
            warnFlag <= 1'b0;
         end
      end
   end

   // Status word gathered from the flag registers; the summary follows either flag.
   assign status = {faultFlag | warnFlag, faultFlag, warnFlag, cmlFlag, invalidFlag};

   // Write decode and validation.
   assign actionWrite = cmd.valid && cmd.write && (cmd.code == `OTFC_CMD_FAULT_ACTION);
   assign actionBad   = (cmd.data[`OTFC_ACTION_RETRY_HI:`OTFC_ACTION_RETRY_LO] != 3'h0) &&
                        (cmd.data[`OTFC_ACTION_RETRY_HI:`OTFC_ACTION_RETRY_LO] != 3'h7);
   assign warnWrite   = cmd.valid && cmd.write && (cmd.code == `OTFC_CMD_WARN_THRESHOLD);
   assign warnBad     = (cmd.data[15:8] != 8'h00) ||
                        (cmd.data[7:0] < `OTFC_WARN_FLOOR) ||
                        (cmd.data[7:0] > `OTFC_WARN_CEIL) ||
                        (!limit_check_bypass && (cmd.data[7:0] >= faultLimit));

   // Restored warning default: fault limit less 25, never below 100.
   always_comb begin
      if (faultLimit < `OTFC_WARN_FLOOR + `OTFC_WARN_OFFSET) begin
         next_warnDefault = `OTFC_WARN_FLOOR;
      end else begin
         next_warnDefault = faultLimit - `OTFC_WARN_OFFSET;
      end
   end

   // Fault action register: only the shutdown bit and retry bit 5 are held.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         actionReg <= `OTFC_ACTION_RESET;
      end else if (restoreDefaults) begin
         actionReg <= {nvmShutdownBit, 1'b0, {6{nvmRetryBit}}};
      end else if (actionWrite && !actionBad) begin
         actionReg <= {cmd.data[`OTFC_ACTION_SHUTDOWN_BIT], 1'b0,
                       {6{cmd.data[`OTFC_ACTION_RETRY_BIT]}}};
      end
   end

   // Warning threshold mantissa; the reset value is the derived default.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         warnReg <= `OTFC_FAULT_DEFAULT - `OTFC_WARN_OFFSET;
      end else if (restoreDefaults) begin
         warnReg <= next_warnDefault;
      end else if (warnWrite && !warnBad) begin
         warnReg <= cmd.data[7:0];
      end
   end

   // Rejected writes set the CML and invalid data bits; a set beats a clear.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmlFlag     <= 1'b0;
         invalidFlag <= 1'b0;
      end else if ((actionWrite && actionBad) || (warnWrite && warnBad)) begin
         cmlFlag     <= 1'b1;
         invalidFlag <= 1'b1;
      end else if (clearFaults) begin
         cmlFlag     <= 1'b0;
         invalidFlag <= 1'b0;
      end
   end

   // Alert stays asserted while any reported condition stands.
   assign smbAlert = status.summaryTempFaultBit | status.cmlBit;

   // Read answer; the exponent field always reads as zero.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdData  <= 16'h0000;
         rdValid <= 1'b0;
      end else begin
         rdValid <= cmd.valid && !cmd.write;
         if (cmd.valid && !cmd.write) begin
            if (cmd.code == `OTFC_CMD_FAULT_ACTION) begin
               rdData <= {8'h00, actionReg};
            end else if (cmd.code == `OTFC_CMD_WARN_THRESHOLD) begin
               rdData <= {`OTFC_WARN_EXPONENT, 3'h0, warnReg};
            end else begin
               rdData <= 16'h0000;
            end
         end
      end
   end

   // Store to memory copies the shutdown bit and the single retry bit.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nvmSave     <= 1'b0;
         nvmSaveData <= 2'h0;
      end else begin
         nvmSave <= storeDefaultAll;
         if (storeDefaultAll) begin
            nvmSaveData <= {actionReg[`OTFC_ACTION_SHUTDOWN_BIT],
                            actionReg[`OTFC_ACTION_RETRY_BIT]};
         end
      end
   end

   // Output control: shut down, hold or wait, then soft start.
   always_comb begin
      next_state = state;
      case (state)
         otfc_pkg::OTFC_RUN: begin
            if (bandgapSync[1]) begin
               next_state = otfc_pkg::OTFC_DOWN;
            end else if (faultSet && actionReg[`OTFC_ACTION_SHUTDOWN_BIT]) begin
               next_state = otfc_pkg::OTFC_DOWN;
            end
         end
         otfc_pkg::OTFC_DOWN: begin
            if (bandgapCause) begin
               if (!bandgapSync[1]) begin
                  next_state = actionReg[`OTFC_ACTION_RETRY_BIT] ?
                               otfc_pkg::OTFC_WAIT : otfc_pkg::OTFC_START;
               end
            end else if (actionReg[`OTFC_ACTION_RETRY_BIT]) begin
               next_state = otfc_pkg::OTFC_WAIT;
            end else if (clearFaults) begin
               next_state = otfc_pkg::OTFC_START;
            end
         end
         otfc_pkg::OTFC_WAIT: begin
            if (bandgapSync[1]) begin
               next_state = otfc_pkg::OTFC_DOWN;
            end else if (riseLeft == 10'h000 && outputCommandOn) begin
               next_state = otfc_pkg::OTFC_START;
            end
         end
         otfc_pkg::OTFC_START: begin
            next_state = otfc_pkg::OTFC_RUN;
         end
         default: begin
            next_state = otfc_pkg::OTFC_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= otfc_pkg::OTFC_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Remember whether the bandgap detector caused the shutdown.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bandgapCause <= 1'b0;
      end else if (state == otfc_pkg::OTFC_RUN || state == otfc_pkg::OTFC_WAIT) begin
         bandgapCause <= bandgapSync[1];
      end
   end

   // Retry delay: seven rise-time units, each counted in milliseconds.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         riseLeft <= 10'h000;
         msCount  <= 32'h0000_0000;
      end else if (state != otfc_pkg::OTFC_WAIT) begin
         riseLeft <= 10'(`OTFC_RETRY_RISE_UNITS * {3'h0, riseTimeMs});
         msCount  <= 32'h0000_0000;
      end else if (riseLeft != 10'h000) begin
         if (msCount == 32'(MS_CYCLES - 1)) begin
            msCount  <= 32'h0000_0000;
            riseLeft <= riseLeft - 10'h001;
         end else begin
            msCount <= msCount + 32'h0000_0001;
         end
      end
   end

   // Output enable and the one-cycle soft-start request come from the state.
   assign outputEnable = (state == otfc_pkg::OTFC_RUN);
   assign softStartReq = (state == otfc_pkg::OTFC_START);

   a_fault_sets: assert property (faultSet |=> status.tempFaultFlag && smbAlert)
      else $error("fault flag or alert missing after threshold crossed");
   a_fault_holds: assert property (
      status.tempFaultFlag && !faultRelease |=> status.tempFaultFlag)
      else $error("fault flag dropped before hysteresis reached");
   a_warn_sets: assert property (
      warnSet |=> status.tempWarningValue && status.summaryTempFaultBit)
      else $error("warning flag missing after threshold crossed");
   a_warn_holds: assert property (
      status.tempWarningValue && !warnRelease |=> status.tempWarningValue)
      else $error("warning flag dropped before hysteresis reached");
   a_ignore_runs: assert property (
      state == otfc_pkg::OTFC_RUN && faultSet && !bandgapSync[1] && !actionReg[7]
      |=> outputEnable)
      else $error("output stopped in ignore mode");
   a_shutdown_stops: assert property (
      state == otfc_pkg::OTFC_RUN && faultSet && actionReg[7] |=> !outputEnable)
      else $error("output kept running in shutdown mode");
   a_bandgap_stops: assert property (
      state == otfc_pkg::OTFC_RUN && bandgapSync[1] |=> !outputEnable)
      else $error("bandgap fault did not stop output");
   a_retry_reject: assert property (
      actionWrite && actionBad && !restoreDefaults
      |=> $stable(actionReg) && status.cmlBit && status.invalidData)
      else $error("bad retry value was accepted");
   a_warn_order: assert property (
      warnWrite && !limit_check_bypass && cmd.data[7:0] >= faultLimit && !restoreDefaults
      |=> $stable(warnReg) && smbAlert)
      else $error("warning at or above fault limit was accepted");
   a_retry_mirror: assert property (
      actionReg[4:0] == {5{actionReg[5]}} && actionReg[6] == 1'b0)
      else $error("retry fields do not mirror bit 5");
   a_hold_off: assert property (
      state == otfc_pkg::OTFC_DOWN && !bandgapCause && !actionReg[5] && !clearFaults
      |=> !outputEnable && !softStartReq)
      else $error("restart attempted with retry disabled");
   a_restore_floor: assert property (restoreDefaults |=> warnReg >= `OTFC_WARN_FLOOR)
      else $error("restored warning below floor");
   a_store_copy: assert property (
      storeDefaultAll |=> nvmSave && nvmSaveData == {$past(actionReg[7]), $past(actionReg[5])})
      else $error("store did not copy fault action bits");
   a_cml_alert: assert property (status.cmlBit |-> smbAlert)
      else $error("alert low while a rejected write is reported");
   a_sample_only: assert property (
      !sample |=> $stable(faultFlag) && $stable(warnFlag))
      else $error("temperature flag changed without a new sample");
   a_wait_delay: assert property (
      state == otfc_pkg::OTFC_WAIT && riseLeft != 10'h000 |=> !softStartReq)
      else $error("soft start requested before the retry delay ran out");

   c_shutdown: cover property (state == otfc_pkg::OTFC_RUN ##1 state == otfc_pkg::OTFC_DOWN);
   c_bandgap_retry: cover property (bandgapCause && state == otfc_pkg::OTFC_DOWN
                                    ##1 state == otfc_pkg::OTFC_WAIT);
   c_retry_start: cover property (state == otfc_pkg::OTFC_WAIT ##1 softStartReq);
   c_reject: cover property (warnWrite && warnBad ##1 status.cmlBit);
   c_warn_release: cover property (status.tempWarningValue ##1 !status.tempWarningValue);

endmodule

/* pkg/otfc_consts.svh */
`ifndef OTFC_CONSTS_SVH
`define OTFC_CONSTS_SVH

// Command codes of the two registers.
`define OTFC_CMD_FAULT_ACTION    8'h50
`define OTFC_CMD_WARN_THRESHOLD  8'h51

// Fault action register layout and reset value.
`define OTFC_ACTION_RESET        8'h3f
`define OTFC_ACTION_SHUTDOWN_BIT 7
`define OTFC_ACTION_RETRY_BIT    5
`define OTFC_ACTION_RETRY_HI     5
`define OTFC_ACTION_RETRY_LO     3

// Warning threshold word layout, whole degrees.
`define OTFC_WARN_EXPONENT       5'h00
`define OTFC_WARN_FLOOR          8'h64
`define OTFC_WARN_CEIL           8'h8c
`define OTFC_WARN_OFFSET         8'h19
`define OTFC_FAULT_DEFAULT       8'h91
`define OTFC_HYST_DEG            8'h14

// Timing: one rise-time unit is one millisecond, retry waits seven units.
`define OTFC_CLK_NS              100
`define OTFC_MS_NS               1000000
`define OTFC_RETRY_RISE_UNITS    10'h007

`endif

/* pkg/otfc_pkg.sv */
package otfc_pkg;

   // Output control state, Gray coded along run, down, wait, start.
   typedef enum logic [1:0] {
      OTFC_RUN   = 2'b00,
      OTFC_DOWN  = 2'b01,
      OTFC_WAIT  = 2'b11,
      OTFC_START = 2'b10
   } otfc_state_e;

   // One host command with its data word.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } otfc_cmd_s;

   // Status bits reported toward the status registers.
   typedef struct packed {
      logic summaryTempFaultBit;
      logic tempFaultFlag;
      logic tempWarningValue;
      logic cmlBit;
      logic invalidData;
   } otfc_status_s;

endpackage

/* verification/otfc_ctrl_test.sv */
`timescale 1ns/1ps
// Self-checking bench for the overtemperature control block.
module otfc_ctrl_test;
   localparam int MsCyc = 4;
   logic                  clk_sys, rst, clearFaults, bandgapOt, limit_check_bypass;
   logic                  outputCommandOn, restoreDefaults, nvmShutdownBit, nvmRetryBit;
   logic                  storeDefaultAll, nvmSave, rdValid, tempClk, smbAlert;
   logic                  outputEnable, softStartReq;
   logic [1:0]            nvmSaveData;
   logic [7:0]            tempValue, faultLimit;
   logic [6:0]            riseTime;
   logic [15:0]           rdData;
   otfc_pkg::otfc_cmd_s   cmd;
   otfc_pkg::otfc_status_s status;
   int                    errTotal, checkCount, cycles;

   // Design with a shortened millisecond.
   otfc_ctrl #(.MS_CYCLES(MsCyc)) i_dut (
      .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .rdData(rdData), .rdValid(rdValid),
      .clearFaults(clearFaults), .tempClk(tempClk), .tempValue(tempValue),
      .bandgapOt(bandgapOt), .faultLimit(faultLimit), .riseTimeMs(riseTime),
      .limit_check_bypass(limit_check_bypass), .outputCommandOn(outputCommandOn),
      .restoreDefaults(restoreDefaults), .nvmShutdownBit(nvmShutdownBit),
      .nvmRetryBit(nvmRetryBit), .storeDefaultAll(storeDefaultAll), .nvmSave(nvmSave),
      .nvmSaveData(nvmSaveData), .status(status), .smbAlert(smbAlert),
      .outputEnable(outputEnable), .softStartReq(softStartReq));

   // Host and sensor on the far side.
   otfc_host_model i_host (.clk_sys(clk_sys), .cmd(cmd), .rdData(rdData), .rdValid(rdValid),
      .tempClk(tempClk), .tempValue(tempValue));

   // Clock at 10 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Hang guard: far above the few hundred cycles the tests need.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errTotal++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checkCount, errTotal);
      if (errTotal == 0 && checkCount > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checkCount++;
      if (seen !== exp) begin
         errTotal++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Lets n edges pass, then samples just after the last one.
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      logic [15:0] v;
      i_host.issue(1'b1, c, d, v);
   endtask

   task automatic rdCheck(input logic [7:0] c, input logic [15:0] exp);
      logic [15:0] v;
      i_host.issue(1'b0, c, 16'h0000, v);
      check(v, exp);
   endtask

   task automatic clr;
      @(posedge clk_sys);
      clearFaults <= 1'b1;
      @(posedge clk_sys);
      clearFaults <= 1'b0;
      step(1);
   endtask

   // Polls for the restart pulse for at most max cycles.
   task automatic waitStart(input int max, output logic found, output int n);
      n = 0;
      do begin
         step(1);
         n++;
      end while (softStartReq !== 1'b1 && n < max);
      found = (softStartReq === 1'b1);
   endtask

   // Reset values of both registers and the idle outputs.
   task automatic t_reset;
      rdCheck(8'h50, 16'h003f);
      rdCheck(8'h51, 16'h0078);
      check(16'({smbAlert, outputEnable}), 16'h0001);
   endtask

   // Every retry code; only the two uniform ones are kept.
   task automatic t_action;
      logic [15:0] last;
      logic        ok;
      last = 16'h003f;
      for (int v = 0; v < 8; v++) begin
         ok = (v == 0 || v == 7);
         wr(8'h50, 16'(v << 3));
         check(16'({status.cmlBit, status.invalidData, smbAlert}), ok ? 16'h0 : 16'h7);
         if (ok) last = (v == 7) ? 16'h003f : 16'h0000;
         rdCheck(8'h50, last);
         clr();
      end
      wr(8'h50, 16'h00ff);
      rdCheck(8'h50, 16'h00bf);
      wr(8'h50, 16'h00c7);
      rdCheck(8'h50, 16'h0080);
      check(16'({status.cmlBit, smbAlert}), 16'h0000);
   endtask

   // Warning writes: {data, fault limit, bypass, accepted}.
   localparam logic [25:0] WTab [8] = '{
      {16'h0064, 8'h91, 2'b01}, {16'h0063, 8'h91, 2'b00}, {16'h008c, 8'h91, 2'b01},
      {16'h008d, 8'h96, 2'b00}, {16'h0182, 8'h91, 2'b00}, {16'h0082, 8'h82, 2'b00},
      {16'h0082, 8'h82, 2'b11}, {16'h0081, 8'h82, 2'b01}};
   task automatic t_warn;
      logic [15:0] last;
      last = 16'h0078;
      foreach (WTab[i]) begin
         @(posedge clk_sys);
         faultLimit <= WTab[i][9:2];
         limit_check_bypass <= WTab[i][1];
         wr(8'h51, WTab[i][25:10]);
         check(16'({status.cmlBit, status.invalidData, smbAlert}),
               WTab[i][0] ? 16'h0 : 16'h7);
         if (WTab[i][0]) last = WTab[i][25:10];
         rdCheck(8'h51, last);
         clr();
      end
      @(posedge clk_sys);
      faultLimit <= 8'h91;
      limit_check_bypass <= 1'b0;
   endtask

   // Threshold crossings with ignore response: {temp, warn, fault}.
   localparam logic [9:0] HTab [8] = '{{8'd120, 2'b00}, {8'd121, 2'b10}, {8'd145, 2'b10},
      {8'd146, 2'b11}, {8'd126, 2'b11}, {8'd125, 2'b10}, {8'd101, 2'b10}, {8'd100, 2'b00}};
   task automatic t_hyst;
      logic w, f;
      wr(8'h51, 16'h0078);
      wr(8'h50, 16'h0038);
      foreach (HTab[i]) begin
         w = HTab[i][1];
         f = HTab[i][0];
         i_host.sample(HTab[i][9:2]);
         step(1);
         check(16'({status.tempWarningValue, status.tempFaultFlag, status.summaryTempFaultBit,
                    smbAlert, outputEnable}),
               16'({w, f, w | f, w | f, 1'b1}));
      end
   endtask

   // Shutdown with endless retry: each restart comes seven rise times later.
   task automatic t_retry111;
      logic found;
      int   n;
      wr(8'h50, 16'h00b8);
      for (int r = 2; r > 0; r--) begin
         @(posedge clk_sys);
         riseTime <= 7'(r);
         i_host.sample(8'd146);
         step(1);
         check(16'({status.tempFaultFlag, outputEnable}), 16'h0002);
         i_host.sample(8'd125);
         waitStart(60, found, n);
         check(16'(found && n + 9 >= 7 * MsCyc * r && n + 9 <= 7 * MsCyc * r + 3),
               16'h1);
         step(1);
         check(16'(outputEnable), 16'h0001);
      end
   endtask

   // Shutdown without retry: held off until the faults are cleared.
   task automatic t_retry000;
      logic found;
      int   n;
      wr(8'h50, 16'h0080);
      i_host.sample(8'd146);
      step(1);
      check(16'(outputEnable), 16'h0000);
      i_host.sample(8'd125);
      waitStart(60, found, n);
      check(16'({found, outputEnable}), 16'h0000);
      @(posedge clk_sys);
      clearFaults <= 1'b1;
      @(posedge clk_sys);
      clearFaults <= 1'b0;
      #1;
      check(16'({softStartReq, outputEnable}), 16'h0002);
      step(1);
      check(16'({softStartReq, outputEnable}), 16'h0001);
   endtask

   // Bandgap faults shut down even in ignore mode and follow the retry delay.
   task automatic t_bandgap;
      logic found;
      int   n;
      for (int k = 0; k < 2; k++) begin
         wr(8'h50, k ? 16'h0038 : 16'h0000);
         @(posedge clk_sys);
         bandgapOt <= 1'b1;
         step(5);
         check(16'(outputEnable), 16'h0000);
         @(posedge clk_sys);
         bandgapOt <= 1'b0;
         waitStart(k ? 10 : 8, found, n);
         check(16'(found), k ? 16'h0000 : 16'h0001);
         if (k) waitStart(40, found, n);
         check(16'(found), 16'h0001);
      end
   endtask

   // Store and restore: {fault limit, shutdown bit, retry bit, warn, action}.
   localparam logic [33:0] RTab [2] = '{{8'd110, 2'b10, 8'h64, 16'h0080},
      {8'd135, 2'b01, 8'h6e, 16'h003f}};
   task automatic t_nvm;
      @(posedge clk_sys);
      storeDefaultAll <= 1'b1;
      @(posedge clk_sys);
      storeDefaultAll <= 1'b0;
      #1;
      check(16'({nvmSave, nvmSaveData}), 16'h0005);
      step(1);
      check(16'(nvmSave), 16'h0000);
      foreach (RTab[i]) begin
         @(posedge clk_sys);
         faultLimit <= RTab[i][33:26];
         {nvmShutdownBit, nvmRetryBit} <= RTab[i][25:24];
         restoreDefaults <= 1'b1;
         @(posedge clk_sys);
         restoreDefaults <= 1'b0;
         rdCheck(8'h51, 16'(RTab[i][23:16]));
         rdCheck(8'h50, RTab[i][15:0]);
      end
   endtask

   // Main sequence.
   initial begin
      {rst, clearFaults, bandgapOt, limit_check_bypass, restoreDefaults} = 5'b10000;
      {nvmShutdownBit, nvmRetryBit, storeDefaultAll, outputCommandOn} = 4'b0001;
      faultLimit = 8'h91;
      riseTime = 7'h01;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      step(4);
      t_reset();
      t_action();
      t_warn();
      t_hyst();
      t_retry111();
      t_retry000();
      t_bandgap();
      t_nvm();
      tally_and_finish();
   end
endmodule

/* verification/otfc_host_model.sv */
`timescale 1ns/1ps
// Host and sensor stand-in: issues register commands and temperature frames.
module otfc_host_model (
   // Clock.
   input  wire logic            clk_sys,
   // Command port and read answer.
   output otfc_pkg::otfc_cmd_s  cmd,
   input  wire logic [15:0]     rdData,
   input  wire logic            rdValid,
   // Sensor link.
   output logic                 tempClk,
   output logic [7:0]           tempValue
);
   // Idle levels at time zero.
   initial begin
      cmd = '0;
      tempClk = 1'b0;
      tempValue = 8'h00;
   end

   // One command for one cycle; released lines show the inverse so stale data never matches.
   task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] val);
      @(posedge clk_sys);
      cmd <= '{valid: 1'b1, write: wr, code: code, data: data};
      @(posedge clk_sys);
      cmd <= '{valid: 1'b0, write: ~wr, code: ~code, data: ~data};
      #1;
      val = (rdValid === 1'b1) ? rdData : 16'hdead;
   endtask

   // One 800 ns frame: value settles in the low half, the clock stands low after it.
   task automatic sample(input logic [7:0] t);
      @(posedge clk_sys);
      tempValue <= t;
      repeat (3) @(posedge clk_sys);
      tempClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      tempClk <= 1'b0;
      tempValue <= ~t;
   endtask
endmodule
